// ===== usr_pkg.sv
package usr_pkg;
  localparam int        STAGES      = 4;
  localparam int        CMD_W       = 8;
  localparam int        FIFO_DEPTH  = 8;
  localparam logic [1:0] MODE_HOLD  = 2'h0;
  localparam logic [1:0] MODE_RIGHT = 2'h1;
  localparam logic [1:0] MODE_LEFT  = 2'h2;
  localparam logic [1:0] MODE_LOAD  = 2'h3;
  localparam logic [3:0] STAGE_RST  = 4'h0;
  // command word layout
  localparam int        CMD_MODE_HI = 7;
  localparam int        CMD_MODE_LO = 6;
  localparam int        CMD_SER_L   = 5;
  localparam int        CMD_SER_R   = 4;
  localparam int        CMD_PAR_HI  = 3;
  localparam int        CMD_PAR_LO  = 0;
endpackage

// ===== usr_fifo.sv
`timescale 1ns/10ps
module usr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ===== usr_shift4.sv
`timescale 1ns/10ps
// Behaviour
// - clear low forces all four stages low regardless of other inputs.
// - clear high, shift clock low: stages keep their levels; here queued edges still pop and move them then.
// - stages change only on rising shift clock, never high or falling; here edges are queued and apply on pop, or drop if full.
// - mode 11 on rising edge loads parallel A..D into stages 0..3.
// - mode 01 shifts right: stage 0 takes right serial input.
// - mode 10 shifts left: stage 3 takes left serial input.
// - mode 00 holds all stages whatever the clock or data.
module usr_shift4 (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // device pins
  input  wire logic       clear_n,
  input  wire logic       shift_clk,
  input  wire logic       mode_sel_hi,
  input  wire logic       mode_sel_lo,
  input  wire logic       ser_left,
  input  wire logic       ser_right,
  input  wire logic [3:0] par_in,
  // edge acceptance
  output logic            edge_ready,
  // stage outputs
  output logic            stage_out_0,
  output logic            stage_out_1,
  output logic            stage_out_2,
  output logic            stage_out_3,
  // result stream
  output logic            word_valid,
  input  wire logic       word_ready,
  output logic [3:0]      word_data
);
  logic                      clk_prev;
  logic                      clk_rise;
  logic                      cmd_push;
  logic [usr_pkg::CMD_W-1:0] cmd_in;
  logic                      cmd_valid;
  logic                      cmd_pop;
  logic [usr_pkg::CMD_W-1:0] cmd;
  logic [1:0]                cmd_mode;
  logic [3:0]                stage;
  logic [3:0]                next_stage;

  // pins are sampled on core_clk; driver keeps levels steady around the edge
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_prev <= 1'b0;
    end else begin
      clk_prev <= shift_clk;
    end
  end

  // only low-to-high is an event; high level and falling edge do nothing
  assign clk_rise = shift_clk & ~clk_prev;
  assign cmd_in   = {mode_sel_hi, mode_sel_lo, ser_left, ser_right, par_in};
  // hold mode is never queued, so it cannot disturb the stages
  assign cmd_push = clk_rise & clear_n & (mode_sel_hi | mode_sel_lo);

  usr_fifo #(
    .WIDTH (usr_pkg::CMD_W),
    .DEPTH (usr_pkg::FIFO_DEPTH)
  ) u_cmd_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .flush     (~clear_n),
    .in_valid  (cmd_push),
    .in_ready  (edge_ready),
    .in_data   (cmd_in),
    .out_valid (cmd_valid),
    .out_ready (cmd_pop),
    .out_data  (cmd)
  );

  // result sink stalls the queue; full queue drops edges and shows edge_ready low
  assign cmd_pop  = cmd_valid & word_ready & clear_n;
  assign cmd_mode = {cmd[usr_pkg::CMD_MODE_HI], cmd[usr_pkg::CMD_MODE_LO]};

  always_comb begin
    next_stage = stage;
    case (cmd_mode)
      usr_pkg::MODE_LOAD: begin
        next_stage = cmd[usr_pkg::CMD_PAR_HI:usr_pkg::CMD_PAR_LO];
      end
      usr_pkg::MODE_RIGHT: begin
        next_stage = {stage[2:0], cmd[usr_pkg::CMD_SER_R]};
      end
      usr_pkg::MODE_LEFT: begin
        next_stage = {cmd[usr_pkg::CMD_SER_L], stage[3:1]};
      end
      default: begin
        next_stage = stage;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage <= usr_pkg::STAGE_RST;
    end else if (!clear_n) begin
      stage <= usr_pkg::STAGE_RST;
    end else if (cmd_pop) begin
      stage <= next_stage;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n || !clear_n) begin
      word_valid <= 1'b0;
      word_data  <= usr_pkg::STAGE_RST;
    end else begin
      word_valid <= cmd_pop;
      if (cmd_pop) begin
        word_data <= next_stage;
      end
    end
  end

  assign stage_out_0 = stage[0];
  assign stage_out_1 = stage[1];
  assign stage_out_2 = stage[2];
  assign stage_out_3 = stage[3];
endmodule

// ===== usr_shift4_properties.sv
`timescale 1ns/10ps
module usr_shift4_chk (
  input wire logic       core_clk, rst_n, clear_n, shift_clk, mode_sel_hi, mode_sel_lo,
  input wire logic       ser_left, ser_right, edge_ready, word_valid, word_ready,
  input wire logic       stage_out_0, stage_out_1, stage_out_2, stage_out_3,
  input wire logic [3:0] par_in, word_data
);
  logic prv;
  wire [3:0] q  = {stage_out_3, stage_out_2, stage_out_1, stage_out_0};
  wire [1:0] md = {mode_sel_hi, mode_sel_lo};
  // only edges accepted by a non-full queue while the sink is ready; they answer two cycles later
  wire       tk = shift_clk && !prv && clear_n && edge_ready && word_ready;
  always_ff @(posedge core_clk) begin
    prv <= rst_n ? shift_clk : 1'b0;
  end
  default clocking ck @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_clear_zero: assert property (!clear_n |=> q == 4'h0 && !word_valid)
    else $error("stages not cleared");
  chk_no_change: assert property ($changed(q) |-> word_valid || $past(!clear_n))
    else $error("stages moved without an op");
  chk_word_match: assert property (word_valid |-> word_data == q)
    else $error("word differs from stages");
  // capture edge, pop one edge later, result sampled the edge after that
  chk_word_after: assert property (tk && md != 2'h0 ##1 word_ready |=> word_valid)
    else $error("op not applied");
  chk_load_par: assert property (tk && md == 2'h3 ##1 word_ready |=> q == $past(par_in, 2))
    else $error("bad load");
  chk_shift_right: assert property (tk && md == 2'h1 ##1 word_ready
    |=> q == {$past(q[2:0], 2), $past(ser_right, 2)}) else $error("bad right shift");
  chk_shift_left: assert property (tk && md == 2'h2 ##1 word_ready
    |=> q == {$past(ser_left, 2), $past(q[3:1], 2)}) else $error("bad left shift");
  chk_hold_mode: assert property (tk && md == 2'h0 ##1 word_ready
    |=> !word_valid && $stable(q)) else $error("hold mode moved");
endmodule
bind usr_shift4 usr_shift4_chk chk (.*);

// ===== usr_board.sv
`timescale 1ns/10ps
module usr_board (
  input  wire logic core_clk,
  output logic      clear_n, shift_clk, mode_sel_hi, mode_sel_lo, ser_left, ser_right,
  output logic [3:0] par_in
);
  initial {clear_n, shift_clk, mode_sel_hi, mode_sel_lo, ser_left, ser_right, par_in} = '0;
  task automatic clr(input logic v);
    @(negedge core_clk) clear_n = v;
  endtask
  // levels settle a full cycle before shift clock rises
  task automatic op(input logic [1:0] m, input logic sl, sr, input logic [3:0] p);
    @(negedge core_clk) {mode_sel_hi, mode_sel_lo, ser_left, ser_right, par_in} = {m, sl, sr, p};
    @(negedge core_clk) shift_clk = 1'b1;
    @(negedge core_clk) shift_clk = 1'b0;
    @(negedge core_clk);
  endtask
endmodule

// ===== usr_shift4_tb.sv
`timescale 1ns/10ps
module usr_shift4_tb;
  logic core_clk = 0, rst_n = 0, word_ready = 1;
  wire clear_n, shift_clk, mode_sel_hi, mode_sel_lo, ser_left, ser_right, edge_ready;
  wire stage_out_0, stage_out_1, stage_out_2, stage_out_3, word_valid;
  wire [3:0] par_in, word_data;
  wire [3:0] q = {stage_out_3, stage_out_2, stage_out_1, stage_out_0};
  int err_total = 0, n_compared = 0;
  always #4 core_clk = ~core_clk;
  usr_board brd (.*);
  usr_shift4 dut (.*);
  task automatic cmp(input logic [3:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t stages %h want %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic t_load;
    brd.op(2'h3, 1'b0, 1'b0, 4'hA); cmp(q, 4'hA);
    cmp_bit(word_valid, 1'b1);
    cmp(word_data, 4'hA);
    @(negedge core_clk) cmp_bit(word_valid, 1'b0);
    brd.op(2'h3, 1'b1, 1'b1, 4'h5); cmp(q, 4'h5);
    $display("load done");
  endtask
  task automatic t_shift;
    brd.op(2'h1, 1'b0, 1'b1, 4'h0); cmp(q, 4'hB);
    brd.op(2'h1, 1'b1, 1'b0, 4'hF); cmp(q, 4'h6);
    brd.op(2'h2, 1'b1, 1'b0, 4'h0); cmp(q, 4'hB);
    brd.op(2'h2, 1'b0, 1'b1, 4'hF); cmp(q, 4'h5);
    $display("shift done");
  endtask
  task automatic t_hold_clear;
    brd.op(2'h0, 1'b1, 1'b1, 4'hF); cmp(q, 4'h5);
    brd.clr(1'b0);
    brd.op(2'h3, 1'b0, 1'b0, 4'hE); cmp(q, 4'h0);
    brd.clr(1'b1);
    $display("hold and clear done");
  endtask
  task automatic t_stall;
    @(negedge core_clk) word_ready = 1'b0;
    brd.op(2'h3, 1'b0, 1'b0, 4'h9); cmp(q, 4'h0);
    brd.op(2'h3, 1'b0, 1'b0, 4'hC);
    word_ready = 1'b1;
    for (int i = 0; i < 20 && q !== 4'hC; i++) @(negedge core_clk);
    cmp(q, 4'hC);
    $display("stall done");
  endtask
  task automatic t_full;
    @(negedge core_clk) word_ready = 1'b0;
    for (int i = 0; i < 8; i++) brd.op(2'h3, 1'b0, 1'b0, 4'(i));
    cmp_bit(edge_ready, 1'b0);
    brd.op(2'h3, 1'b0, 1'b0, 4'hF);
    word_ready = 1'b1;
    for (int i = 0; i < 30 && q !== 4'h7; i++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
    cmp(q, 4'h7);
    cmp_bit(edge_ready, 1'b1);
    $display("full done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d bad %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge core_clk);
    rst_n = 1'b1;
    brd.clr(1'b1);
    t_load();
    t_shift();
    t_hold_clear();
    t_stall();
    t_full();
    tally_and_finish();
  end
endmodule
